// >>> logic/mbcc_brake_cmd.sv
`timescale 1ns/1ps
// Functional notes
// RULE1 - A FET brake issues two to the power of the pulse-count field plus one pulses.
// RULE2 - Each pulse on-phase lasts two to the power of the on-time field times 11.24 us.
// RULE3 - Each off-phase lasts the off multiplier times the on-phase, none when it is zero.
// RULE4 - Speed is too high to brake above (field plus one) times 3.125 % of maximum speed.
// RULE5 - Too high a speed causes a coast of two to the power of field plus one timer ticks.
// RULE6 - Back-EMF compensation amplitude is field times 0.390625 %, and zero disables it.
// RULE7 - The rotor is stationary below (field plus one) times 0.0244140625 % of max speed.
// RULE8 - The observer is unreliable below (field plus one) times 0.1953125 % of max speed.
// RULE9 - The default external command is field times 1.5625 % of the maximum command.
// RULE10 - The motor turns on once the command exceeds (field plus one) times 0.390625 %.
// RULE11 - The motor turns off once the command falls below field times 0.390625 %.
// RULE12 - The brake-type bit picks low-side FET pulses at zero, constant current at one.
// RULE13 - The pulse train alternates on and off phases, stops at the count, then FETs stay off.
module mbcc_brake_cmd
  import mbcc_pkg::*;
#(
  parameter int BRAKE_UNIT_CYCLES = MBCC_BRAKE_UNIT_CYCLES
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  output logic [31:0] reg_rdata,
  input wire logic [15:0] rotor_speed,
  input wire logic [15:0] command_level,
  input wire logic brake_request,
  input wire logic timer_tick,
  output logic lowside_on,
  output logic current_brake_on,
  output logic coasting,
  output logic brake_busy,
  output logic overspeed,
  output logic standstill,
  output logic observer_unreliable,
  output logic motor_run,
  output logic backemf_comp_enable,
  output logic [15:0] backemf_comp_level,
  output logic [15:0] fallback_command_level
);
  logic [31:0] brake_cfg, thresh_shadow, thresh_nvm;
  logic [31:0] next_brake_cfg, next_thresh_shadow, next_thresh_nvm, next_reg_rdata;
  mbcc_state_type state, next_state;
  logic [8:0] pulses_done, next_pulses_done;
  logic [7:0] coast_ticks, next_coast_ticks;
  logic next_lowside_on, next_current_brake_on, next_coasting, next_brake_busy;
  logic next_overspeed, next_standstill, next_observer_unreliable, next_motor_run;
  logic next_backemf_comp_enable;
  logic [15:0] next_backemf_comp_level, next_fallback_command_level;
  logic timer_load, timer_expired;
  logic [MBCC_TIMER_WIDTH-1:0] timer_value, high_cycles, low_cycles;
  logic [2:0] count_exp, high_exp, coast_exp;
  logic [1:0] low_mult;
  logic [16:0] overspeed_limit;
  logic [15:0] standstill_limit, observer_limit;
  logic [16:0] run_limit;
  logic [15:0] halt_limit;

  // Scales an N-bit field (plus an optional one) onto the 16-bit full scale
  function automatic logic [16:0] mbcc_scale(input logic [6:0] field, input logic plus_one,
                                              input int shift);
    logic [16:0] wide;
    wide = {10'h000, field} + {16'h0000, plus_one};
    return 17'(wide << shift);
  endfunction : mbcc_scale

  assign count_exp = brake_cfg[MBCC_PULSE_COUNT_LSB +: 3];
  assign high_exp = brake_cfg[MBCC_HIGH_TIME_LSB +: 3];
  assign low_mult = brake_cfg[MBCC_LOW_MULT_LSB +: 2];
  assign coast_exp = brake_cfg[MBCC_COAST_LSB +: 3];
  assign high_cycles = MBCC_TIMER_WIDTH'(BRAKE_UNIT_CYCLES) << high_exp; // RULE2
  assign low_cycles = MBCC_TIMER_WIDTH'(high_cycles * low_mult); // RULE3
  assign overspeed_limit =
    mbcc_scale({2'b00, brake_cfg[MBCC_OVERSPEED_LSB +: 5]}, 1'b1, MBCC_OVERSPEED_SHIFT);
  assign standstill_limit =
    16'(mbcc_scale(thresh_shadow[MBCC_STANDSTILL_LSB +: 7], 1'b1, MBCC_STANDSTILL_SHIFT));
  assign observer_limit =
    16'(mbcc_scale({4'h0, thresh_shadow[MBCC_OBSERVER_LSB +: 3]}, 1'b1, MBCC_OBSERVER_SHIFT));
  assign run_limit =
    mbcc_scale({1'b0, thresh_shadow[MBCC_RUN_LSB +: 6]}, 1'b1, MBCC_CMD_SHIFT);
  assign halt_limit =
    16'(mbcc_scale({1'b0, thresh_shadow[MBCC_HALT_LSB +: 6]}, 1'b0, MBCC_CMD_SHIFT));

  // Register file
  always_comb begin
    next_brake_cfg = brake_cfg;
    next_thresh_shadow = thresh_shadow;
    next_thresh_nvm = thresh_nvm;
    if (reg_write) begin
      case (reg_addr)
        MBCC_ADDR_BRAKE_CFG: next_brake_cfg = reg_wdata;
        MBCC_ADDR_THRESH_SHADOW: next_thresh_shadow = reg_wdata;
        MBCC_ADDR_THRESH_NVM: next_thresh_nvm = reg_wdata;
        default: next_brake_cfg = brake_cfg;
      endcase
    end
    case (reg_addr)
      MBCC_ADDR_BRAKE_CFG: next_reg_rdata = brake_cfg;
      MBCC_ADDR_THRESH_SHADOW: next_reg_rdata = thresh_shadow;
      MBCC_ADDR_THRESH_NVM: next_reg_rdata = thresh_nvm;
      default: next_reg_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      brake_cfg <= MBCC_RESET_VALUE;
      thresh_shadow <= MBCC_RESET_VALUE;
      thresh_nvm <= MBCC_RESET_VALUE;
      reg_rdata <= 32'h0000_0000;
    end else begin
      brake_cfg <= next_brake_cfg;
      thresh_shadow <= next_thresh_shadow;
      thresh_nvm <= next_thresh_nvm;
      reg_rdata <= next_reg_rdata;
    end
  end

  // Speed and command thresholds
  always_comb begin
    next_overspeed = {1'b0, rotor_speed} > overspeed_limit; // RULE4
    next_standstill = rotor_speed < standstill_limit; // RULE7
    next_observer_unreliable = rotor_speed < observer_limit; // RULE8
    next_motor_run = motor_run;
    if ({1'b0, command_level} > run_limit) begin
      next_motor_run = 1'b1; // RULE10
    end else if (command_level < halt_limit) begin
      next_motor_run = 1'b0; // RULE11
    end
    next_backemf_comp_level =
      16'(mbcc_scale({1'b0, brake_cfg[MBCC_BACKEMF_LSB +: 6]}, 1'b0, MBCC_BACKEMF_SHIFT)); // RULE6
    next_backemf_comp_enable = brake_cfg[MBCC_BACKEMF_LSB +: 6] != 6'h00; // RULE6
    next_fallback_command_level =
      16'(mbcc_scale({1'b0, thresh_shadow[MBCC_FALLBACK_LSB +: 6]}, 1'b0,
                     MBCC_FALLBACK_SHIFT)); // RULE9
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      overspeed <= 1'b0;
      standstill <= 1'b0;
      observer_unreliable <= 1'b0;
      motor_run <= 1'b0;
      backemf_comp_level <= 16'h0000;
      backemf_comp_enable <= 1'b0;
      fallback_command_level <= 16'h0000;
    end else begin
      overspeed <= next_overspeed;
      standstill <= next_standstill;
      observer_unreliable <= next_observer_unreliable;
      motor_run <= next_motor_run;
      backemf_comp_level <= next_backemf_comp_level;
      backemf_comp_enable <= next_backemf_comp_enable;
      fallback_command_level <= next_fallback_command_level;
    end
  end

  mbcc_phase_timer u_phase_timer (
    .core_clk(core_clk),
    .reset(reset),
    .load(timer_load),
    .load_value(timer_value),
    .expired(timer_expired)
  );

  // Brake sequencer
  always_comb begin
    next_state = state;
    next_pulses_done = pulses_done;
    next_coast_ticks = coast_ticks;
    timer_load = 1'b0;
    timer_value = high_cycles;
    case (state)
      MBCC_IDLE: begin
        if (brake_request) begin
          if (brake_cfg[MBCC_BRAKE_TYPE_BIT]) begin
            next_state = MBCC_CURRENT_BRAKE; // RULE12
          end else if (overspeed) begin
            next_state = MBCC_COAST; // RULE5
            next_coast_ticks = 8'h00;
          end else begin
            next_state = MBCC_PULSE_HIGH; // RULE12
            next_pulses_done = 9'h000;
            timer_load = 1'b1;
          end
        end
      end
      MBCC_COAST: begin
        if (timer_tick) begin
          next_coast_ticks = coast_ticks + 8'h01;
          if ({1'b0, coast_ticks} + 9'h001 == (9'h001 << ({1'b0, coast_exp} + 4'h1))) begin // RULE5
            next_state = MBCC_IDLE;
          end
        end
      end
      MBCC_PULSE_HIGH: begin
        if (timer_expired) begin
          next_pulses_done = pulses_done + 9'h001;
          if (pulses_done + 9'h001 == (9'h001 << ({1'b0, count_exp} + 4'h1))) begin // RULE1
            next_state = MBCC_DONE; // RULE13
          end else if (low_mult == 2'h0) begin
            next_state = MBCC_PULSE_HIGH; // RULE3
            timer_load = 1'b1;
          end else begin
            next_state = MBCC_PULSE_LOW; // RULE13
            timer_load = 1'b1;
            timer_value = low_cycles;
          end
        end
      end
      MBCC_PULSE_LOW: begin
        if (timer_expired) begin
          next_state = MBCC_PULSE_HIGH; // RULE13
          timer_load = 1'b1;
        end
      end
      MBCC_CURRENT_BRAKE: begin
        if (!brake_request) begin
          next_state = MBCC_IDLE;
        end
      end
      MBCC_DONE: begin
        if (!brake_request) begin
          next_state = MBCC_IDLE;
        end
      end
      default: next_state = MBCC_IDLE;
    endcase
    next_lowside_on = next_state == MBCC_PULSE_HIGH; // RULE13
    next_current_brake_on = next_state == MBCC_CURRENT_BRAKE;
    next_coasting = next_state == MBCC_COAST;
    next_brake_busy = next_state != MBCC_IDLE && next_state != MBCC_DONE;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state <= MBCC_IDLE;
      pulses_done <= 9'h000;
      coast_ticks <= 8'h00;
      lowside_on <= 1'b0;
      current_brake_on <= 1'b0;
      coasting <= 1'b0;
      brake_busy <= 1'b0;
    end else begin
      state <= next_state;
      pulses_done <= next_pulses_done;
      coast_ticks <= next_coast_ticks;
      lowside_on <= next_lowside_on;
      current_brake_on <= next_current_brake_on;
      coasting <= next_coasting;
      brake_busy <= next_brake_busy;
    end
  end
endmodule : mbcc_brake_cmd

// >>> logic/mbcc_phase_timer.sv
`timescale 1ns/1ps
module mbcc_phase_timer
  import mbcc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [MBCC_TIMER_WIDTH-1:0] load_value,
  output logic expired
);
  logic [MBCC_TIMER_WIDTH-1:0] count;
  logic [MBCC_TIMER_WIDTH-1:0] next_count;

  // Expired marks the last of load_value cycles, so the caller moves on exactly on time
  assign expired = count == {{(MBCC_TIMER_WIDTH-1){1'b0}}, 1'b1};

  always_comb begin
    next_count = count;
    if (load) begin
      next_count = load_value;
    end else if (count != '0) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end
endmodule : mbcc_phase_timer

// >>> logic/mbcc_pkg.sv
package mbcc_pkg;
  // Register addresses, word addressed as the serial port presents them
  localparam logic [11:0] MBCC_ADDR_BRAKE_CFG = 12'h471;
  localparam logic [11:0] MBCC_ADDR_THRESH_SHADOW = 12'h472;
  localparam logic [11:0] MBCC_ADDR_THRESH_NVM = 12'h4D2;
  localparam logic [31:0] MBCC_RESET_VALUE = 32'h0000_0000;

  // Brake configuration fields
  localparam int MBCC_BRAKE_TYPE_BIT = 0;
  localparam int MBCC_PULSE_COUNT_LSB = 8;
  localparam int MBCC_HIGH_TIME_LSB = 11;
  localparam int MBCC_LOW_MULT_LSB = 14;
  localparam int MBCC_OVERSPEED_LSB = 16;
  localparam int MBCC_COAST_LSB = 21;
  localparam int MBCC_BACKEMF_LSB = 26;

  // Threshold register fields
  localparam int MBCC_STANDSTILL_LSB = 0;
  localparam int MBCC_OBSERVER_LSB = 7;
  localparam int MBCC_FALLBACK_LSB = 10;
  localparam int MBCC_RUN_LSB = 16;
  localparam int MBCC_HALT_LSB = 22;

  // Scale shifts onto a 16-bit full scale (65536 = 100 %)
  localparam int MBCC_OVERSPEED_SHIFT = 11;
  localparam int MBCC_STANDSTILL_SHIFT = 4;
  localparam int MBCC_OBSERVER_SHIFT = 7;
  localparam int MBCC_FALLBACK_SHIFT = 10;
  localparam int MBCC_CMD_SHIFT = 8;
  localparam int MBCC_BACKEMF_SHIFT = 8;

  // Timing
  localparam int MBCC_CLK_PERIOD_PS = 4000;
  localparam int MBCC_BRAKE_UNIT_PS = 11240000;
  localparam int MBCC_BRAKE_UNIT_CYCLES =
    (MBCC_BRAKE_UNIT_PS + MBCC_CLK_PERIOD_PS - 1) / MBCC_CLK_PERIOD_PS;
  localparam int MBCC_TIMER_WIDTH = 22;

  typedef enum logic [5:0] {
    MBCC_IDLE = 6'h01,
    MBCC_COAST = 6'h02,
    MBCC_PULSE_HIGH = 6'h04,
    MBCC_PULSE_LOW = 6'h08,
    MBCC_CURRENT_BRAKE = 6'h10,
    MBCC_DONE = 6'h20
  } mbcc_state_type;
endpackage : mbcc_pkg

// >>> tb/mbcc_brake_cmd_asserts.sv
`timescale 1ns/1ps
module mbcc_brake_cmd_chk
  import mbcc_pkg::*;
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_write,
  input wire logic [31:0] reg_rdata,
  input wire logic [15:0] rotor_speed,
  input wire logic [15:0] command_level,
  input wire logic brake_request,
  input wire logic lowside_on,
  input wire logic current_brake_on,
  input wire logic coasting,
  input wire logic brake_busy,
  input wire logic overspeed,
  input wire logic standstill,
  input wire logic observer_unreliable,
  input wire logic motor_run,
  input wire logic backemf_comp_enable,
  input wire logic [15:0] backemf_comp_level,
  input wire logic [15:0] fallback_command_level
);
  logic [31:0] cfg, thr, nvm, rd_x;
  logic ovs_x, std_x, obs_x, on_x, off_x;
  // Mirror of the stored words so outputs can be tied to their fields
  always_ff @(posedge core_clk) begin
    if (reset) begin
      cfg <= MBCC_RESET_VALUE;
      thr <= MBCC_RESET_VALUE;
      nvm <= MBCC_RESET_VALUE;
    end else if (reg_write) begin
      if (reg_addr == MBCC_ADDR_BRAKE_CFG) cfg <= reg_wdata;
      if (reg_addr == MBCC_ADDR_THRESH_SHADOW) thr <= reg_wdata;
      if (reg_addr == MBCC_ADDR_THRESH_NVM) nvm <= reg_wdata;
    end
  end
  always_comb begin
    ovs_x = {1'b0, rotor_speed} > ((17'(cfg[20:16]) + 17'h00001) << 11);
    std_x = {1'b0, rotor_speed} < ((17'(thr[6:0]) + 17'h00001) << 4);
    obs_x = {1'b0, rotor_speed} < ((17'(thr[9:7]) + 17'h00001) << 7);
    on_x = {1'b0, command_level} > ((17'(thr[21:16]) + 17'h00001) << 8);
    off_x = {1'b0, command_level} < (17'(thr[27:22]) << 8);
    rd_x = (reg_addr == MBCC_ADDR_BRAKE_CFG) ? cfg :
      (reg_addr == MBCC_ADDR_THRESH_SHADOW) ? thr :
      (reg_addr == MBCC_ADDR_THRESH_NVM) ? nvm : 32'h00000000;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence take_s;
    !brake_busy && $rose(brake_request);
  endsequence
  chk_speed_over: assert property (!$past(reset) |-> overspeed == $past(ovs_x))
    else $error("overspeed wrong");
  chk_rotor_still: assert property (!$past(reset) |-> standstill == $past(std_x))
    else $error("standstill wrong");
  chk_observer_weak: assert property (!$past(reset) |-> observer_unreliable == $past(obs_x))
    else $error("observer flag wrong");
  chk_fallback_value: assert property (##1 fallback_command_level == {$past(thr[15:10]), 10'h000})
    else $error("fallback level wrong");
  chk_backemf_value: assert property (##1 backemf_comp_level == {2'b00, $past(cfg[31:26]), 8'h00}
    && backemf_comp_enable == |$past(cfg[31:26])) else $error("backemf wrong");
  chk_run_hyst: assert property (!$past(reset) |->
    motor_run == ($past(on_x) || ($past(motor_run) && !$past(off_x)))) else $error("run wrong");
  chk_read_path: assert property (!$past(reset) |-> reg_rdata == $past(rd_x))
    else $error("read data wrong");
  chk_fet_start: assert property (take_s ##0 (!cfg[0] && !overspeed) |=> lowside_on && brake_busy)
    else $error("pulse train did not start");
  chk_coast_start: assert property (take_s ##0 (!cfg[0] && overspeed) |=> coasting && !lowside_on)
    else $error("coast did not start");
  chk_current_start: assert property (take_s ##0 cfg[0] |=> current_brake_on && !lowside_on)
    else $error("current brake did not start");
  chk_idle_quiet: assert property (!brake_busy |-> !lowside_on && !coasting)
    else $error("outputs active while idle");
endmodule : mbcc_brake_cmd_chk
bind mbcc_brake_cmd mbcc_brake_cmd_chk chk (.core_clk, .reset, .reg_addr, .reg_wdata, .reg_write,
  .reg_rdata, .rotor_speed, .command_level, .brake_request, .lowside_on, .current_brake_on,
  .coasting, .brake_busy, .overspeed, .standstill, .observer_unreliable, .motor_run,
  .backemf_comp_enable, .backemf_comp_level, .fallback_command_level);

// >>> tb/mbcc_bridge_model.sv
`timescale 1ns/1ps
module mbcc_bridge_model (
  input wire logic core_clk,
  input wire logic clr,
  input wire logic lowside_on,
  output int n_pulses,
  output int on_len,
  output int off_len
);
  int run;
  logic last;
  // Low-side legs follow the gate; each level run is timed when it ends
  always @(posedge core_clk) begin
    if (clr) begin
      n_pulses <= 0;
      run <= 0;
      last <= 1'b0;
    end else begin
      run <= (lowside_on === last) ? run + 1 : 1;
      last <= lowside_on;
      if (lowside_on && !last) n_pulses <= n_pulses + 1;
      if (!lowside_on && last) on_len <= run;
      if (lowside_on && !last && n_pulses > 0) off_len <= run;
    end
  end
endmodule : mbcc_bridge_model

// >>> tb/tb_motor_brake_cmd_config.sv
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin mismatches++; \
  $display("BAD %s exp %0h got %0h", nm, e, s); end end
module tb_motor_brake_cmd_config;
  import mbcc_pkg::*;
  localparam int UNIT = 4;
  logic core_clk, reset, reg_write, brake_request, timer_tick, clr, run_m;
  logic lowside_on, current_brake_on, coasting, brake_busy, overspeed, standstill;
  logic observer_unreliable, motor_run, backemf_comp_enable;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, seed, cfg, thr, v;
  logic [15:0] rotor_speed, command_level, bl, fl;
  int mismatches, n_checks, n_pulses, on_len, off_len, k;
  mbcc_brake_cmd #(.BRAKE_UNIT_CYCLES(UNIT)) dut (.core_clk, .reset, .reg_addr, .reg_wdata,
    .reg_write, .reg_rdata, .rotor_speed, .command_level, .brake_request, .timer_tick,
    .lowside_on, .current_brake_on, .coasting, .brake_busy, .overspeed, .standstill,
    .observer_unreliable, .motor_run, .backemf_comp_enable, .backemf_comp_level(bl),
    .fallback_command_level(fl));
  mbcc_bridge_model bridge (.core_clk, .clr, .lowside_on, .n_pulses, .on_len, .off_len);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic run_f(input logic r);
    if ({1'b0, command_level} > ((17'(thr[21:16]) + 17'h00001) << 8)) return 1'b1;
    if ({1'b0, command_level} < (17'(thr[27:22]) << 8)) return 1'b0;
    return r;
  endfunction : run_f
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    repeat (2) @(posedge core_clk);
    #1 `CHK("rdata", e, reg_rdata)
  endtask : rd
  task automatic tick_at(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick_at
  task automatic tally_and_finish();
    if (mismatches == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    tick_at(40000);
    mismatches++;
    tally_and_finish();
  end
  initial begin
    {reset, reg_write, brake_request, timer_tick, clr, run_m} = 6'h20;
    {reg_addr, reg_wdata, rotor_speed, command_level} = '0;
    seed = 32'h98C04BFB;
    tick_at(4);
    reset <= 1'b0;
    rd(MBCC_ADDR_BRAKE_CFG, 32'h00000000);
    rd(MBCC_ADDR_THRESH_NVM, 32'h00000000);
    v = rnd();
    wr(MBCC_ADDR_THRESH_NVM, v);
    wr(12'h473, rnd());
    rd(MBCC_ADDR_THRESH_NVM, v);
    rd(12'h473, 32'h00000000);
    for (k = 0; k < 150; k++) begin
      v = rnd();
      thr = rnd();
      cfg = rnd() & 32'hFFFFFFFE;
      wr(MBCC_ADDR_THRESH_SHADOW, thr);
      wr(MBCC_ADDR_BRAKE_CFG, cfg);
      rd(MBCC_ADDR_THRESH_SHADOW, thr);
      rd(MBCC_ADDR_BRAKE_CFG, cfg);
      run_m = run_f(run_m);
      rotor_speed <= k[0] ? v[15:0] : 16'((17'(cfg[20:16]) + 17'h00001) << 11);
      command_level <= k[1] ? v[31:16] : 16'(((17'(thr[21:16]) + 17'h00001) << 8) + 17'(k[0]));
      tick_at(3);
      run_m = run_f(run_m);
      `CHK("ovs", {1'b0, rotor_speed} > ((17'(cfg[20:16]) + 17'h1) << 11), overspeed)
      `CHK("still", {1'b0, rotor_speed} < ((17'(thr[6:0]) + 17'h1) << 4), standstill)
      `CHK("obs", {1'b0, rotor_speed} < ((17'(thr[9:7]) + 17'h1) << 7), observer_unreliable)
      `CHK("fallback", {thr[15:10], 10'h000}, fl)
      `CHK("bemf", {|cfg[31:26], 2'b00, cfg[31:26], 8'h00}, {backemf_comp_enable, bl})
      `CHK("run", run_m, motor_run)
    end
    rotor_speed <= 16'h0000;
    for (k = 0; k < 8; k++) begin
      cfg = 32'h001F0000 | (k[0] << 8) | (k[1] << 11) | ((1 + k[2]) << 14);
      wr(MBCC_ADDR_BRAKE_CFG, cfg);
      clr <= 1'b1;
      tick_at(1);
      clr <= 1'b0;
      brake_request <= 1'b1;
      tick_at(3);
      for (int i = 0; i < 3000 && brake_busy !== 1'b0; i++) tick_at(1);
      tick_at(5);
      `CHK("pulses", 2 << k[0], n_pulses)
      `CHK("on_len", UNIT << k[1], on_len)
      `CHK("off_len", (1 + k[2]) * (UNIT << k[1]), off_len)
      `CHK("done", 2'b00, {brake_busy, lowside_on})
      brake_request <= 1'b0;
      tick_at(2);
    end
    // Longest train with no off-phase: the legs stay on for all 256 on-phases
    wr(MBCC_ADDR_BRAKE_CFG, 32'h001F0700);
    clr <= 1'b1;
    tick_at(1);
    clr <= 1'b0;
    brake_request <= 1'b1;
    tick_at(3);
    for (int i = 0; i < 3000 && brake_busy !== 1'b0; i++) tick_at(1);
    tick_at(5);
    `CHK("long_on", 256 * UNIT, on_len)
    `CHK("one_run", 1, n_pulses)
    `CHK("long_done", 2'b00, {brake_busy, lowside_on})
    brake_request <= 1'b0;
    tick_at(2);
    wr(MBCC_ADDR_BRAKE_CFG, 32'h00200000);
    rotor_speed <= 16'h4000;
    tick_at(3);
    brake_request <= 1'b1;
    tick_at(1);
    brake_request <= 1'b0;
    for (k = 0; k < 4; k++) begin
      tick_at(5);
      `CHK("coast", 1'b1, coasting)
      timer_tick <= 1'b1;
      tick_at(1);
      timer_tick <= 1'b0;
    end
    tick_at(3);
    `CHK("coast_end", 2'b00, {coasting, brake_busy})
    wr(MBCC_ADDR_BRAKE_CFG, 32'h00000001);
    brake_request <= 1'b1;
    tick_at(10);
    `CHK("cur_on", 2'b10, {current_brake_on, lowside_on})
    brake_request <= 1'b0;
    tick_at(3);
    `CHK("cur_off", 1'b0, current_brake_on)
    tally_and_finish();
  end
endmodule : tb_motor_brake_cmd_config
